// [mss_defines.vh]
`ifndef MSS_DEFINES_VH
`define MSS_DEFINES_VH

// clocking
`define MSS_CORE_CLK_HZ        40000000
`define MSS_SND_CLK_HZ         32768
`define MSS_SND_DIV_COUNT      (`MSS_CORE_CLK_HZ / `MSS_SND_CLK_HZ)
// sound clocks per thirty-second note for each tempo step
`define MSS_TEMPO_UNIT_TICKS   64

// register byte offsets
`define MSS_OFS_CONTROL        12'h000
`define MSS_OFS_SELECT         12'h004
`define MSS_OFS_BUFFER         12'h008
`define MSS_OFS_FLAGS          12'h00c
`define MSS_OFS_ENABLE         12'h010

// control fields
`define MSS_CTL_STOP_BIT       0
// select fields
`define MSS_SEL_MODE_LSB       0
`define MSS_SEL_MODE_MSB       1
`define MSS_SEL_TIME_LSB       4
`define MSS_SEL_TIME_MSB       7
`define MSS_MODE_MELODY        2'h2
// buffer word fields
`define MSS_BUF_PITCH_LSB      0
`define MSS_BUF_PITCH_MSB      7
`define MSS_BUF_DUR_LSB        8
`define MSS_BUF_DUR_MSB        13
`define MSS_BUF_REST_BIT       14
`define MSS_BUF_TIE_BIT        15
// flag fields
`define MSS_FLG_EMPTY_BIT      0
`define MSS_FLG_DONE_BIT       1
`define MSS_FLG_BUSY_BIT       2

// reset values
`define MSS_RST_SELECT         6'h00
`define MSS_RST_BUFFER         16'h0000
`define MSS_RST_ENABLE         2'h0
`define MSS_RST_EMPTY          1'b1

`endif

// [mss_tone_gen.v]
`timescale 1ns/1ps
`include "mss_defines.vh"

module mss_tone_gen (
    core_clk,
    reset,
    snd_tick,
    tone_on,
    restart,
    pitch_code,
    tone_out_r
);
    input  wire       core_clk;    // system clock
    input  wire       reset;       // synchronous, high
    input  wire       snd_tick;    // one pulse per sound clock
    input  wire       tone_on;     // tone wanted now
    input  wire       restart;     // phase restart at note start
    input  wire [7:0] pitch_code;  // period minus one, in sound clocks
    output reg        tone_out_r;  // square wave, low when off

    reg  [7:0] phase_r;            // position in current period
    wire [8:0] period;             // pitch code plus one
    wire [7:0] half;               // high part of the period

    assign period = {1'b0, pitch_code} + 9'h001;
    assign half   = period[8:1];

    // period counter, one full cycle every pitch+1 sound clocks
    always @(posedge core_clk) begin
        if (reset || restart) begin
            phase_r <= 8'h00;
        end else if (snd_tick) begin
            if (phase_r >= pitch_code) begin
                phase_r <= 8'h00;
            end else begin
                phase_r <= phase_r + 8'h01;
            end
        end
    end

    // output level; steady low while silent
    always @(posedge core_clk) begin
        if (reset || !tone_on) begin
            tone_out_r <= 1'b0;
        end else begin
            tone_out_r <= (phase_r < half);
        end
    end
endmodule // mss_tone_gen

// [mss_melody_seq.v]
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "mss_defines.vh"

module mss_melody_seq (
    core_clk,
    reset,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    irq,
    buzzer_out
);
    input  wire        core_clk;    // 40 MHz system clock
    input  wire        reset;       // synchronous, active high
    input  wire        psel;        // apb select
    input  wire        penable;     // apb access phase
    input  wire        pwrite;      // apb direction
    input  wire [11:0] paddr;       // apb byte address
    input  wire [31:0] pwdata;      // apb write data
    output reg  [31:0] prdata;      // apb read data
    output reg         pready;      // apb ready
    output reg         pslverr;     // apb error on unmapped address
    output reg         irq;         // level interrupt
    output wire        buzzer_out;  // sound pin

    localparam integer DIV_LAST_I  = `MSS_SND_DIV_COUNT - 1;  // divider end, full width
    localparam integer TEMPO_MUL_I = `MSS_TEMPO_UNIT_TICKS;   // tempo base, full width
    localparam [10:0]  DIV_LAST    = DIV_LAST_I[10:0];        // 1219 fits eleven bits
    localparam [6:0]   TEMPO_MUL   = TEMPO_MUL_I[6:0];        // 64 fits seven bits

    // address decode, shared by error response and write strobes
    function is_mapped;
        input [11:0] a;
        begin
            is_mapped = (a == `MSS_OFS_CONTROL) || (a == `MSS_OFS_SELECT) ||
                        (a == `MSS_OFS_BUFFER)  || (a == `MSS_OFS_FLAGS)  ||
                        (a == `MSS_OFS_ENABLE);
        end
    endfunction

    // note length in thirty-second units; every code is valid and gives code plus one units
    function [6:0] note_units;
        input [5:0] code;
        begin
            note_units = {1'b0, code} + 7'h01;
        end
    endfunction

    // register state
    reg  [5:0]  select_r;       // mode [1:0], tempo [5:2]
    reg  [15:0] buffer_r;       // pending note word
    reg         buf_full_r;     // pending word not yet taken
    reg  [15:0] active_r;       // note word now playing
    reg         empty_flag_r;   // buffer empty flag
    reg         done_flag_r;    // output completion flag
    reg         busy_r;         // output busy flag
    reg  [1:0]  enable_r;       // interrupt enables
    // timing state
    reg  [10:0] div_r;          // core to sound clock divider
    reg         snd_tick_r;     // one pulse per sound clock
    reg  [10:0] unit_cnt_r;     // sound clocks left in this unit
    reg  [6:0]  note_cnt_r;     // units left in this note
    reg         restart_r;      // tone phase restart pulse

    wire        wr_access;      // write completes this edge
    wire        setup;          // setup cycle of any transfer
    wire        wr_ctl;         // control write
    wire        wr_sel;         // select write
    wire        wr_buf;         // buffer write
    wire        wr_flg;         // flags write
    wire        wr_en;          // enable write
    wire        melody_mode;    // melody selected
    wire        stop_req;       // software stop
    wire        first_load;     // idle start with a waiting word
    wire        note_end;       // current note just ran out
    wire        trigger;        // internal tempo trigger
    wire        load_word;      // trigger with word waiting
    wire        finish;         // trigger with no word
    wire [10:0] unit_len;       // sound clocks per unit, minus one
    wire        tone_on;        // tone sounding now
    wire [31:0] rd_mux;         // read data before flop

    assign setup       = psel && !penable;
    assign wr_access   = psel && penable && pready && pwrite && is_mapped(paddr);
    assign wr_ctl      = wr_access && (paddr == `MSS_OFS_CONTROL);
    assign wr_sel      = wr_access && (paddr == `MSS_OFS_SELECT);
    assign wr_buf      = wr_access && (paddr == `MSS_OFS_BUFFER);
    assign wr_flg      = wr_access && (paddr == `MSS_OFS_FLAGS);
    assign wr_en       = wr_access && (paddr == `MSS_OFS_ENABLE);
    assign melody_mode = (select_r[1:0] == `MSS_MODE_MELODY);
    assign stop_req    = wr_ctl && pwdata[`MSS_CTL_STOP_BIT];

    // tempo: each time step adds 64 sound clocks per unit; max 1023 fits
    assign unit_len    = {1'b0, select_r[5:2], 6'h00} + {4'h0, TEMPO_MUL} - 11'h001;
    // triggers: start at the next sound clock when idle, else at end of each note
    assign first_load  = snd_tick_r && melody_mode && !busy_r && buf_full_r;
    assign note_end    = snd_tick_r && busy_r && (unit_cnt_r == 11'h000) &&
                         (note_cnt_r == 7'h01);
    assign trigger     = first_load || note_end;
    assign load_word   = trigger && buf_full_r;
    assign finish      = note_end && !buf_full_r;
    assign tone_on     = busy_r && !active_r[`MSS_BUF_REST_BIT];

    // sound clock enable from the core clock
    always @(posedge core_clk) begin
        if (reset) begin
            div_r      <= 11'h000;
            snd_tick_r <= 1'b0;
        end else if (div_r == DIV_LAST) begin
            div_r      <= 11'h000;
            snd_tick_r <= 1'b1;
        end else begin
            div_r      <= div_r + 11'h001;
            snd_tick_r <= 1'b0;
        end
    end

    // control registers written by software
    always @(posedge core_clk) begin
        if (reset) begin
            select_r <= `MSS_RST_SELECT;
            enable_r <= `MSS_RST_ENABLE;
        end else begin
            if (wr_sel) begin
                select_r <= {pwdata[`MSS_SEL_TIME_MSB:`MSS_SEL_TIME_LSB],
                             pwdata[`MSS_SEL_MODE_MSB:`MSS_SEL_MODE_LSB]};
            end
            if (wr_en) begin
                enable_r <= pwdata[1:0];
            end
        end
    end

    // one-entry sound buffer; a write in the trigger cycle refills it
    always @(posedge core_clk) begin
        if (reset) begin
            buffer_r   <= `MSS_RST_BUFFER;
            buf_full_r <= 1'b0;
        end else if (wr_buf) begin
            buffer_r   <= pwdata[15:0];
            buf_full_r <= 1'b1;
        end else if (load_word || stop_req) begin
            buf_full_r <= 1'b0;
        end
    end

    // active sound register and note timing
    always @(posedge core_clk) begin
        if (reset) begin
            active_r   <= `MSS_RST_BUFFER;
            busy_r     <= 1'b0;
            unit_cnt_r <= 11'h000;
            note_cnt_r <= 7'h00;
            restart_r  <= 1'b0;
        end else begin
            restart_r <= 1'b0;
            if (stop_req || (busy_r && !melody_mode)) begin
                // stop cuts the note at once and drops any waiting word
                busy_r <= 1'b0;
            end else if (load_word) begin
                active_r   <= buffer_r;
                busy_r     <= 1'b1;
                unit_cnt_r <= unit_len;
                note_cnt_r <= note_units(buffer_r[`MSS_BUF_DUR_MSB:`MSS_BUF_DUR_LSB]);
                // a tied note keeps the running phase, no retrigger
                restart_r  <= !(buffer_r[`MSS_BUF_TIE_BIT] && busy_r);
            end else if (finish) begin
                busy_r <= 1'b0;
            end else if (snd_tick_r && busy_r) begin
                if (unit_cnt_r == 11'h000) begin
                    unit_cnt_r <= unit_len;
                    note_cnt_r <= note_cnt_r - 7'h01;
                end else begin
                    unit_cnt_r <= unit_cnt_r - 11'h001;
                end
            end
        end
    end

    // sticky flags; hardware set beats a flags-register clear, but a buffer write beats the empty set
    always @(posedge core_clk) begin
        if (reset) begin
            empty_flag_r <= `MSS_RST_EMPTY;
            done_flag_r  <= 1'b0;
        end else begin
            if (wr_buf) begin
                empty_flag_r <= 1'b0;
            end else if (load_word || stop_req) begin
                empty_flag_r <= 1'b1;
            end else if (wr_flg && pwdata[`MSS_FLG_EMPTY_BIT]) begin
                empty_flag_r <= 1'b0;
            end
            if (finish) begin
                done_flag_r <= 1'b1;
            end else if (wr_buf || (wr_flg && pwdata[`MSS_FLG_DONE_BIT])) begin
                done_flag_r <= 1'b0;
            end
        end
    end

    // interrupt: flag and its enable
    always @(posedge core_clk) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= (empty_flag_r && enable_r[0]) || (done_flag_r && enable_r[1]);
        end
    end

    // read mux; reserved bits read zero
    assign rd_mux = (paddr == `MSS_OFS_SELECT) ? {24'h0, select_r[5:2], 2'h0, select_r[1:0]} :
                    (paddr == `MSS_OFS_BUFFER) ? {16'h0, buffer_r} :
                    (paddr == `MSS_OFS_FLAGS)  ? {29'h0, busy_r, done_flag_r, empty_flag_r} :
                    (paddr == `MSS_OFS_ENABLE) ? {30'h0, enable_r} :
                    32'h0;

    // apb slave: ready rises for the access phase, no wait states
    always @(posedge core_clk) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else if (setup) begin
            pready  <= 1'b1;
            pslverr <= !is_mapped(paddr);
            prdata  <= pwrite ? 32'h0 : rd_mux;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // tone generator drives the pin from its own flop
    mss_tone_gen u_tone (
        .core_clk   (core_clk),
        .reset      (reset),
        .snd_tick   (snd_tick_r),
        .tone_on    (tone_on),
        .restart    (restart_r),
        .pitch_code (active_r[`MSS_BUF_PITCH_MSB:`MSS_BUF_PITCH_LSB]),
        .tone_out_r (buzzer_out)
    );
endmodule // mss_melody_seq

// [mss_seq_properties.sv]
`timescale 1ns/1ps
`include "mss_defines.vh"
module mss_seq_properties (
    input wire        core_clk,
    input wire        reset,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        irq,
    input wire        buzzer_out
);
    // decoded register hit
    wire       mapped = (paddr == `MSS_OFS_CONTROL) || (paddr == `MSS_OFS_SELECT) ||
                        (paddr == `MSS_OFS_BUFFER) || (paddr == `MSS_OFS_FLAGS) ||
                        (paddr == `MSS_OFS_ENABLE);
    wire       wr_done = psel && penable && pready && pwrite;  // write lands now
    reg  [1:0] enable_r;                                        // shadow of enable bits

    // shadow follows completed enable writes only
    always @(posedge core_clk) begin
        if (reset) begin
            enable_r <= 2'h0;
        end else if (wr_done && (paddr == `MSS_OFS_ENABLE)) begin
            enable_r <= pwdata[1:0];
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    setup_ready_a: assert property (psel && !penable |=> pready)
        else $error("ready missing after setup");
    ready_phase_a: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    unmapped_err_a: assert property (pready && !mapped |-> pslverr)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (pready && mapped |-> !pslverr)
        else $error("mapped access refused");
    write_zero_a: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("read data during write");
    enable_read_a: assert property (
        pready && !pwrite && (paddr == `MSS_OFS_ENABLE) |-> prdata == {30'h0, enable_r})
        else $error("enable readback wrong");
    irq_masked_a: assert property (
        (enable_r == 2'h0) && ($past(enable_r) == 2'h0) |-> !irq)
        else $error("interrupt while all masked");
    tone_half_a: assert property ($rose(buzzer_out) |=> buzzer_out [*8])
        else $error("tone high half too short");
endmodule // mss_seq_properties

bind mss_melody_seq mss_seq_properties u_props (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .buzzer_out(buzzer_out));

// [mss_buzzer_model.sv]
`timescale 1ns/1ps
module mss_buzzer_model (
    input  wire         core_clk,
    input  wire         buzzer_out,
    output logic [31:0] high_len = 32'h0,
    output logic [31:0] low_len  = 32'h0,
    output logic [31:0] edges    = 32'h0
);
    logic [31:0] run_r  = 32'h0;  // cycles since last pin change
    logic        prev_r = 1'b0;   // pin level at last edge

    // a piezo only sees edges; time each half wave in core clocks
    always @(posedge core_clk) begin
        run_r <= run_r + 32'h1;
        prev_r <= buzzer_out;
        if (buzzer_out !== prev_r) begin
            edges <= edges + 32'h1;
            run_r <= 32'h1;
            if (prev_r) begin
                high_len <= run_r;
            end else begin
                low_len <= run_r;
            end
        end
    end
endmodule // mss_buzzer_model

// [tb_melody_sound_sequencer.sv]
`timescale 1ns/1ps
`include "mss_defines.vh"
module tb_melody_sound_sequencer;
    logic        core_clk = 1'b0;   // 40 MHz
    logic        reset    = 1'b1;   // held two cycles
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [11:0] paddr    = 12'h000;
    logic [31:0] pwdata   = 32'h0;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire         irq;
    wire         buzzer_out;
    wire  [31:0] high_len;
    wire  [31:0] low_len;
    wire  [31:0] edges;
    integer      miscompares = 0;
    integer      checked     = 0;
    logic [31:0] rdat;              // last read data
    logic        rerr;              // last error response
    logic [31:0] snap;              // edge count before a rest

    always #12.5 core_clk = ~core_clk;

    mss_melody_seq uut (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .buzzer_out(buzzer_out));
    mss_buzzer_model u_buzz (.core_clk(core_clk), .buzzer_out(buzzer_out),
        .high_len(high_len), .low_len(low_len), .edges(edges));

    task close_out;
        begin
            if (miscompares == 0 && checked > 0) begin
                $display("RESULT: PASS");
            end else begin
                $display("RESULT: FAIL");
            end
            $finish;
        end
    endtask

    task chk(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("ERROR %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // one apb transfer; ready wait is bounded
    task xfer(input [11:0] a, input w, input [31:0] d);
        integer i;
        begin
            @(posedge core_clk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge core_clk);
            penable <= 1'b1;
            i = 0;
            do begin
                @(posedge core_clk);
                i = i + 1;
            end while (pready !== 1'b1 && i < 16);
            rdat = prdata;
            rerr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            if (pready !== 1'b1) begin
                miscompares = miscompares + 1;
                $display("ERROR %0t: no ready from slave", $time);
                close_out;
            end
        end
    endtask

    task rd(input [11:0] a, input [31:0] m, input [31:0] exp);
        begin
            xfer(a, 1'b0, 32'h0);
            chk(rdat & m, exp);
        end
    endtask

    // poll busy; a note at tempo 0 takes about 78k clocks
    task wait_busy(input v);
        integer n;
        begin
            n = 0;
            do begin
                xfer(`MSS_OFS_FLAGS, 1'b0, 32'h0);
                n = n + 1;
            end while (rdat[2] !== v && n < 30000);
            if (rdat[2] !== v) begin
                miscompares = miscompares + 1;
                $display("ERROR %0t: busy flag never reached %0d", $time, v);
                close_out;
            end
        end
    endtask

    // irq is registered one cycle behind the flags
    task irq_is(input e);
        begin
            repeat (2) @(posedge core_clk);
            chk({31'h0, irq}, {31'h0, e});
        end
    endtask

    initial begin
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        rd(`MSS_OFS_ENABLE, 32'hffffffff, 32'h0);
        rd(`MSS_OFS_FLAGS, 32'h7, 32'h1);
        rd(12'h014, 32'hffffffff, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        xfer(12'h014, 1'b1, 32'h3);
        chk({31'h0, rerr}, 32'h1);
        irq_is(1'b0);
        xfer(`MSS_OFS_ENABLE, 1'b1, 32'h1);
        irq_is(1'b1);
        xfer(`MSS_OFS_SELECT, 1'b1, 32'h2);
        xfer(`MSS_OFS_BUFFER, 1'b1, 32'h0001);
        rd(`MSS_OFS_FLAGS, 32'h7, 32'h0);
        irq_is(1'b0);
        wait_busy(1'b1);
        chk(rdat & 32'h7, 32'h5);
        irq_is(1'b1);
        xfer(`MSS_OFS_ENABLE, 1'b1, 32'h2);
        irq_is(1'b0);
        wait_busy(1'b0);
        chk(rdat & 32'h7, 32'h3);
        irq_is(1'b1);
        chk({31'h0, buzzer_out}, 32'h0);
        chk(high_len, `MSS_SND_DIV_COUNT);
        chk(low_len, `MSS_SND_DIV_COUNT);
        xfer(`MSS_OFS_FLAGS, 1'b1, 32'h2);
        rd(`MSS_OFS_FLAGS, 32'h7, 32'h1);
        irq_is(1'b0);
        xfer(`MSS_OFS_BUFFER, 1'b1, 32'h4001);
        wait_busy(1'b1);
        snap = edges;
        repeat (3000) @(posedge core_clk);
        chk(edges, snap);
        chk({31'h0, buzzer_out}, 32'h0);
        xfer(`MSS_OFS_BUFFER, 1'b1, 32'h0001);
        rd(`MSS_OFS_FLAGS, 32'h1, 32'h0);
        xfer(`MSS_OFS_CONTROL, 1'b1, 32'h1);
        rd(`MSS_OFS_FLAGS, 32'h1, 32'h1);
        close_out;
    end
endmodule // tb_melody_sound_sequencer
